// >>> hdl/step_seq_pkg.sv
package step_seq_pkg;

    localparam int          STEP_COUNT       = 8;
    localparam int          STEP_IDX_W       = 3;
    localparam int          DWELL_W          = 16;
    localparam int          WORD_W           = 16;

    // byte addresses: eight program words, eight dwell words, control, status, eight speed words
    localparam logic [7:0]  PROG_BASE        = 8'h00;
    localparam logic [7:0]  DWELL_BASE       = 8'h20;
    localparam logic [7:0]  CTRL_ADDR        = 8'h40;
    localparam logic [7:0]  STATUS_ADDR      = 8'h44;
    localparam logic [7:0]  SPEED_BASE       = 8'h60;
    localparam logic [15:0] PROG_RESET       = 16'h00f1;
    localparam logic [15:0] DWELL_RESET      = 16'h000a;
    localparam logic [15:0] SPEED_RESET      = 16'h0000;

    // dwell tick: 0.1 s at 10 MHz
    localparam int          DWELL_TICK_NS    = 100000000;
    localparam int          CLK_PERIOD_NS    = 100;
    localparam int          TICK_CYCLES      = DWELL_TICK_NS / CLK_PERIOD_NS;

    // digit positions
    localparam int          ACT_LSB          = 12;
    localparam int          TGT_LSB          = 8;
    localparam int          JMP_LSB          = 4;
    localparam int          ADV_LSB          = 0;

    // action digit
    localparam logic [3:0]  ACT_GROUP2_MIN   = 4'h6;
    localparam logic [3:0]  ACT_MAX          = 4'hb;

    // target digit
    localparam logic [3:0]  TGT_STEP_MAX     = 4'h7;
    localparam logic [3:0]  TGT_STOP_RAMP    = 4'h8;
    localparam logic [3:0]  TGT_STOP_COAST   = 4'h9;
    localparam logic [3:0]  TGT_ABORT        = 4'ha;

    // condition digit
    localparam logic [3:0]  COND_SKIP        = 4'h0;
    localparam logic [3:0]  COND_TIMED      = 4'h1;
    localparam logic [3:0]  COND_A_ON        = 4'h2;
    localparam logic [3:0]  COND_B_ON        = 4'h3;
    localparam logic [3:0]  COND_A_OFF       = 4'h4;
    localparam logic [3:0]  COND_B_OFF       = 4'h5;
    localparam logic [3:0]  COND_OR          = 4'h6;
    localparam logic [3:0]  COND_AND         = 4'h7;
    localparam logic [3:0]  COND_NOR         = 4'h8;
    localparam logic [3:0]  COND_A_ONLY      = 4'h9;
    localparam logic [3:0]  COND_B_ONLY      = 4'ha;
    localparam logic [3:0]  COND_T_A_ON      = 4'hb;
    localparam logic [3:0]  COND_T_B_ON      = 4'hc;
    localparam logic [3:0]  COND_T_A_OFF     = 4'hd;
    localparam logic [3:0]  COND_T_B_OFF     = 4'he;
    localparam logic [3:0]  COND_IGNORE      = 4'hf;

    // direction codes
    localparam logic [1:0]  DIR_FWD          = 2'h0;
    localparam logic [1:0]  DIR_REV          = 2'h1;
    localparam logic [1:0]  DIR_NONE         = 2'h2;

    // control / status bits
    localparam int          CTRL_START_BIT   = 0;
    localparam int          CTRL_STOP_BIT    = 1;
    localparam int          CTRL_FCLR_BIT    = 2;

    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_RUN     = 2'b01,
        SEQ_STOPPED = 2'b11
    } seq_state_type;

endpackage : step_seq_pkg

// >>> hdl/step_condition.sv
`timescale 1ns/1ps
`default_nettype none
module step_condition (
    // condition code and inputs
    input  wire logic [3:0] code,
    input  wire logic       dwell_done,
    input  wire logic       in_a,
    input  wire logic       in_b,
    // result
    output logic            met
);
    always_comb begin
        case (code)
            step_seq_pkg::COND_SKIP:    met = 1'b1;
            step_seq_pkg::COND_TIMED:   met = dwell_done;
            step_seq_pkg::COND_A_ON:    met = in_a;
            step_seq_pkg::COND_B_ON:    met = in_b;
            step_seq_pkg::COND_A_OFF:   met = !in_a;
            step_seq_pkg::COND_B_OFF:   met = !in_b;
            step_seq_pkg::COND_OR:      met = in_a | in_b;
            step_seq_pkg::COND_AND:     met = in_a & in_b;
            step_seq_pkg::COND_NOR:     met = !(in_a | in_b);
            step_seq_pkg::COND_A_ONLY:  met = in_a & !in_b;
            step_seq_pkg::COND_B_ONLY:  met = in_b & !in_a;
            step_seq_pkg::COND_T_A_ON:  met = dwell_done & in_a;
            step_seq_pkg::COND_T_B_ON:  met = dwell_done & in_b;
            step_seq_pkg::COND_T_A_OFF: met = dwell_done & !in_a;
            step_seq_pkg::COND_T_B_OFF: met = dwell_done & !in_b;
            default:                    met = 1'b0;
        endcase
    end
endmodule : step_condition
`default_nettype wire

// >>> hdl/step_sequencer.sv
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module step_sequencer (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // drive side
    input  wire logic        start_cmd,
    input  wire logic        stop_cmd,
    input  wire logic        drive_fault,
    input  wire logic        logic_input_a,
    input  wire logic        logic_input_b,
    // commands to the drive
    output logic             running,
    output logic [2:0]       step_index,
    output logic [15:0]      preset_speed,
    output logic             ramp_set2,
    output logic             step_output_on,
    output logic [1:0]       direction,
    output logic             stop_ramped,
    output logic             stop_coast,
    output logic             program_abort_fault
);
    localparam int TICK_W = $clog2(step_seq_pkg::TICK_CYCLES);

    // pin synchronisers
    logic [1:0] sync_a_q, sync_b_q, sync_start_q, sync_stop_q, sync_flt_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_a_q     <= 2'h0;
            sync_b_q     <= 2'h0;
            sync_start_q <= 2'h0;
            sync_stop_q  <= 2'h0;
            sync_flt_q   <= 2'h0;
        end else begin
            sync_a_q     <= {sync_a_q[0], logic_input_a};
            sync_b_q     <= {sync_b_q[0], logic_input_b};
            sync_start_q <= {sync_start_q[0], start_cmd};
            sync_stop_q  <= {sync_stop_q[0], stop_cmd};
            sync_flt_q   <= {sync_flt_q[0], drive_fault};
        end
    end
    logic in_a, in_b, start_lvl, stop_lvl, fault_lvl;
    assign in_a      = sync_a_q[1];
    assign in_b      = sync_b_q[1];
    assign start_lvl = sync_start_q[1];
    assign stop_lvl  = sync_stop_q[1];
    assign fault_lvl = sync_flt_q[1];

    logic start_prev_q;
    always_ff @(posedge clk) begin
        if (!rst_n) start_prev_q <= 1'b0;
        else        start_prev_q <= start_lvl;
    end

    // register file
    logic [15:0] prog_q  [step_seq_pkg::STEP_COUNT];
    logic [15:0] dwell_q [step_seq_pkg::STEP_COUNT];
    logic [15:0] speed_q [step_seq_pkg::STEP_COUNT];
    logic        sw_start_q, sw_stop_q, sw_fclr_q;
    logic        wr_en, rd_en;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & !pwrite;

    genvar gi;
    generate
        for (gi = 0; gi < step_seq_pkg::STEP_COUNT; gi++) begin : g_regs
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    prog_q[gi]  <= step_seq_pkg::PROG_RESET;
                    dwell_q[gi] <= step_seq_pkg::DWELL_RESET;
                    speed_q[gi] <= step_seq_pkg::SPEED_RESET;
                end else if (wr_en) begin
                    if (paddr == step_seq_pkg::PROG_BASE + 8'(4 * gi))
                        prog_q[gi] <= pwdata[15:0];
                    if (paddr == step_seq_pkg::DWELL_BASE + 8'(4 * gi))
                        dwell_q[gi] <= pwdata[15:0];
                    if (paddr == step_seq_pkg::SPEED_BASE + 8'(4 * gi))
                        speed_q[gi] <= pwdata[15:0];
                end
            end
        end
    endgenerate

    // control bits are self-clearing one-cycle pulses
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sw_start_q <= 1'b0;
            sw_stop_q  <= 1'b0;
            sw_fclr_q  <= 1'b0;
        end else begin
            sw_start_q <= wr_en && paddr == step_seq_pkg::CTRL_ADDR && pwdata[step_seq_pkg::CTRL_START_BIT];
            sw_stop_q  <= wr_en && paddr == step_seq_pkg::CTRL_ADDR && pwdata[step_seq_pkg::CTRL_STOP_BIT];
            sw_fclr_q  <= wr_en && paddr == step_seq_pkg::CTRL_ADDR && pwdata[step_seq_pkg::CTRL_FCLR_BIT];
        end
    end

    // sequencer state
    step_seq_pkg::seq_state_type state_q;
    logic [2:0]        step_q;
    logic [TICK_W-1:0] tick_q;
    logic [15:0]       dwell_cnt_q;
    logic              dwell_done;
    logic              enter_q;

    logic [15:0] word;
    logic [3:0]  act_dig, tgt_dig, jmp_dig, adv_dig;
    assign word    = prog_q[step_q];
    assign act_dig = word[step_seq_pkg::ACT_LSB +: 4];
    assign tgt_dig = word[step_seq_pkg::TGT_LSB +: 4];
    assign jmp_dig = word[step_seq_pkg::JMP_LSB +: 4];
    assign adv_dig = word[step_seq_pkg::ADV_LSB +: 4];

    assign dwell_done = (dwell_cnt_q >= dwell_q[step_q]);

    logic jmp_met, adv_met, jump_go, adv_go;
    step_condition u_jmp_cond (
        .code       (jmp_dig),
        .dwell_done (dwell_done),
        .in_a       (in_a),
        .in_b       (in_b),
        .met        (jmp_met)
    );
    step_condition u_adv_cond (
        .code       (adv_dig),
        .dwell_done (dwell_done),
        .in_a       (in_a),
        .in_b       (in_b),
        .met        (adv_met)
    );
    // entry cycle lets the new step's outputs settle before judging it
    assign jump_go = !enter_q && (jmp_dig != step_seq_pkg::COND_IGNORE) && jmp_met;
    assign adv_go  = !enter_q && (adv_dig != step_seq_pkg::COND_IGNORE) && adv_met;

    logic start_ev, stop_ev;
    assign start_ev = (start_lvl & !start_prev_q) | sw_start_q;
    assign stop_ev  = stop_lvl | sw_stop_q | fault_lvl;

    logic abort_set, ramp_end, coast_end;
    assign ramp_end  = jump_go && tgt_dig == step_seq_pkg::TGT_STOP_RAMP;
    assign coast_end = jump_go && tgt_dig == step_seq_pkg::TGT_STOP_COAST;
    assign abort_set = jump_go && tgt_dig == step_seq_pkg::TGT_ABORT;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= step_seq_pkg::SEQ_IDLE;
            step_q  <= 3'h0;
            enter_q <= 1'b0;
        end else begin
            enter_q <= 1'b0;
            case (state_q)
                step_seq_pkg::SEQ_IDLE, step_seq_pkg::SEQ_STOPPED: begin
                    if (start_ev && !stop_ev && !program_abort_fault) begin
                        state_q <= step_seq_pkg::SEQ_RUN;
                        step_q  <= 3'h0;
                        enter_q <= 1'b1;
                    end
                end
                step_seq_pkg::SEQ_RUN: begin
                    if (stop_ev) begin
                        state_q <= step_seq_pkg::SEQ_STOPPED;
                    end else if (jump_go) begin
                        if (tgt_dig <= step_seq_pkg::TGT_STEP_MAX) begin
                            step_q  <= tgt_dig[2:0];
                            enter_q <= 1'b1;
                        end else begin
                            state_q <= step_seq_pkg::SEQ_STOPPED;
                        end
                    end else if (adv_go) begin
                        step_q  <= step_q + 3'h1;
                        enter_q <= 1'b1;
                    end
                end
                default: state_q <= step_seq_pkg::SEQ_IDLE;
            endcase
        end
    end

    // dwell timing in tenths of a second
    always_ff @(posedge clk) begin
        if (!rst_n || enter_q || state_q != step_seq_pkg::SEQ_RUN) begin
            tick_q      <= '0;
            dwell_cnt_q <= 16'h0;
        end else if (tick_q == TICK_W'(step_seq_pkg::TICK_CYCLES - 1)) begin
            tick_q <= '0;
            if (!dwell_done)
                dwell_cnt_q <= dwell_cnt_q + 16'h1;
        end else begin
            tick_q <= tick_q + TICK_W'(1);
        end
    end

    // drive commands
    logic [3:0] act_in_grp;
    assign act_in_grp = (act_dig >= step_seq_pkg::ACT_GROUP2_MIN) ? act_dig - step_seq_pkg::ACT_GROUP2_MIN
                                                                  : act_dig;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            running        <= 1'b0;
            step_index     <= 3'h0;
            preset_speed   <= 16'h0;
            ramp_set2      <= 1'b0;
            step_output_on <= 1'b0;
            direction      <= step_seq_pkg::DIR_NONE;
        end else begin
            running        <= state_q == step_seq_pkg::SEQ_RUN;
            step_index     <= step_q;
            preset_speed   <= speed_q[step_q];
            ramp_set2      <= act_dig >= step_seq_pkg::ACT_GROUP2_MIN;
            step_output_on <= act_in_grp >= 4'h3 && act_dig <= step_seq_pkg::ACT_MAX;
            if (state_q != step_seq_pkg::SEQ_RUN || act_dig > step_seq_pkg::ACT_MAX)
                direction <= step_seq_pkg::DIR_NONE;
            else
                case (act_in_grp)
                    4'h0, 4'h3: direction <= step_seq_pkg::DIR_FWD;
                    4'h1, 4'h4: direction <= step_seq_pkg::DIR_REV;
                    default:    direction <= step_seq_pkg::DIR_NONE;
                endcase
        end
    end

    // stop pulses and abort fault; set wins over clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stop_ramped         <= 1'b0;
            stop_coast          <= 1'b0;
            program_abort_fault <= 1'b0;
        end else begin
            stop_ramped <= state_q == step_seq_pkg::SEQ_RUN && !stop_ev && ramp_end;
            stop_coast  <= state_q == step_seq_pkg::SEQ_RUN && !stop_ev && coast_end;
            if (state_q == step_seq_pkg::SEQ_RUN && !stop_ev && abort_set)
                program_abort_fault <= 1'b1;
            else if (sw_fclr_q)
                program_abort_fault <= 1'b0;
        end
    end

    // apb read side, zero wait states
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & !penable;
            pslverr <= 1'b0;
            if (psel & !penable & !pwrite) begin
                prdata <= 32'h0;
                if (paddr[7:5] == step_seq_pkg::PROG_BASE[7:5])
                    prdata <= {16'h0, prog_q[paddr[4:2]]};
                else if (paddr[7:5] == step_seq_pkg::DWELL_BASE[7:5])
                    prdata <= {16'h0, dwell_q[paddr[4:2]]};
                else if (paddr[7:5] == step_seq_pkg::SPEED_BASE[7:5])
                    prdata <= {16'h0, speed_q[paddr[4:2]]};
                else if (paddr == step_seq_pkg::STATUS_ADDR)
                    prdata <= {24'h0, program_abort_fault, step_q, 2'h0, state_q};
            end
        end
    end

    // checks
    property p_jump_priority;
        @(posedge clk) disable iff (!rst_n)
        (state_q == step_seq_pkg::SEQ_RUN && !stop_ev && jump_go && tgt_dig <= step_seq_pkg::TGT_STEP_MAX)
            |=> step_q == $past(tgt_dig[2:0]);
    endproperty
    a_jump_priority: assert property (p_jump_priority) else $error("jump target not taken");

    property p_wrap;
        @(posedge clk) disable iff (!rst_n)
        (state_q == step_seq_pkg::SEQ_RUN && !stop_ev && !jump_go && adv_go && step_q == 3'h7) |=> step_q == 3'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("step 7 did not wrap");

    property p_start;
        @(posedge clk) disable iff (!rst_n)
        (state_q != step_seq_pkg::SEQ_RUN) ##1 (state_q == step_seq_pkg::SEQ_RUN) |-> step_q == 3'h0;
    endproperty
    a_start: assert property (p_start) else $error("run did not begin at step 0");

    property p_stop;
        @(posedge clk) disable iff (!rst_n)
        (state_q == step_seq_pkg::SEQ_RUN && stop_ev) |=> state_q == step_seq_pkg::SEQ_STOPPED ##1 !running;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not honoured");

    property p_abort;
        @(posedge clk) disable iff (!rst_n)
        (state_q == step_seq_pkg::SEQ_RUN && !stop_ev && abort_set) |=> program_abort_fault
            && state_q == step_seq_pkg::SEQ_STOPPED;
    endproperty
    a_abort: assert property (p_abort) else $error("abort fault missing");

    property p_no_jump_f;
        @(posedge clk) disable iff (!rst_n)
        (jmp_dig == step_seq_pkg::COND_IGNORE) |-> !jump_go;
    endproperty
    a_no_jump_f: assert property (p_no_jump_f) else $error("jump taken with digit F");

    property p_dwell_reset;
        @(posedge clk) disable iff (!rst_n)
        enter_q |=> dwell_cnt_q == 16'h0;
    endproperty
    a_dwell_reset: assert property (p_dwell_reset) else $error("dwell not restarted");

    property p_ramp;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> ramp_set2 == ($past(act_dig) >= step_seq_pkg::ACT_GROUP2_MIN);
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp set wrong");

    property p_skip;
        @(posedge clk) disable iff (!rst_n)
        (state_q == step_seq_pkg::SEQ_RUN && !enter_q && !stop_ev && adv_dig == step_seq_pkg::COND_SKIP
            && jmp_dig == step_seq_pkg::COND_IGNORE) |=> step_q == $past(step_q) + 3'h1;
    endproperty
    a_skip: assert property (p_skip) else $error("skip did not advance");

endmodule : step_sequencer
`default_nettype wire

// >>> bench/drive_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module drive_side_model (
    // clock
    input  wire logic clk,
    // drive commands and logic inputs
    output logic      start_cmd,
    output logic      stop_cmd,
    output logic      drive_fault,
    output logic      logic_input_a,
    output logic      logic_input_b
);
    initial begin
        start_cmd     = 1'b0;
        stop_cmd      = 1'b0;
        drive_fault   = 1'b0;
        logic_input_a = 1'b0;
        logic_input_b = 1'b0;
    end

    // levels move only just after an edge and hold until the next call
    task automatic set_lines(input logic st, input logic sp, input logic fl, input logic a, input logic b);
        @(posedge clk);
        start_cmd     <= st;
        stop_cmd      <= sp;
        drive_fault   <= fl;
        logic_input_a <= a;
        logic_input_b <= b;
    endtask : set_lines
endmodule : drive_side_model
`default_nettype wire

// >>> bench/step_sequencer_program_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module step_sequencer_program_decoder_test;
    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, st, sp, fl, in_a, in_b;
    logic        running, ramp_set2, out_on, s_ramp, s_coast, abort_flt;
    logic [2:0]  step_index;
    logic [15:0] preset_speed;
    logic [1:0]  direction;
    int          fails   = 0;
    int          checked = 0;
    // input pairs {a,b} that hold, then satisfy, condition code k
    logic [1:0]  pat_f [15] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0, 2'h0, 2'h2, 2'h1};
    logic [1:0]  pat_t [15] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h1, 2'h3, 2'h0, 2'h2, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0};

    always #50 clk = ~clk;

    drive_side_model drv_u (.clk(clk), .start_cmd(st), .stop_cmd(sp), .drive_fault(fl),
        .logic_input_a(in_a), .logic_input_b(in_b));

    step_sequencer dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .start_cmd(st), .stop_cmd(sp), .drive_fault(fl), .logic_input_a(in_a), .logic_input_b(in_b),
        .running(running), .step_index(step_index), .preset_speed(preset_speed), .ramp_set2(ramp_set2),
        .step_output_on(out_on), .direction(direction), .stop_ramped(s_ramp), .stop_coast(s_coast),
        .program_abort_fault(abort_flt));

    task automatic wrap_up();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a missing answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        apb(1'b0, a, 32'h0, x);
        chk(x, exp);
        chk(32'(pslverr), 32'h0);
    endtask : rdchk

    task automatic wait_step(input logic [2:0] s);
        int n;
        n = 0;
        while (step_index !== s && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk(32'(step_index), 32'(s));
    endtask : wait_step

    task automatic scen_conds();
        logic [3:0] act;
        for (int k = 0; k < 15; k++) begin
            act = 4'(k % 12);
            wr(step_seq_pkg::PROG_BASE, {16'h0, act, 4'h0, 4'hf, 4'(k)});
            drv_u.set_lines(1'b0, 1'b0, 1'b0, pat_f[k][1], pat_f[k][0]);
            wr(step_seq_pkg::CTRL_ADDR, 32'h1);
            // stale step 1 from the last run would satisfy the wait below
            wait_step(3'h0);
            if (k > 1) begin
                repeat (20) @(posedge clk);
                chk(32'(step_index), 32'h0);
                chk(32'({ramp_set2, out_on, direction, preset_speed}),
                    32'({act >= 4'h6, (act % 6) >= 3, 2'(act % 3), 16'h1234}));
            end
            drv_u.set_lines(1'b0, 1'b0, 1'b0, pat_t[k][1], pat_t[k][0]);
            wait_step(3'h1);
            repeat (10) @(posedge clk);
            chk(32'(step_index), 32'h1);
            wr(step_seq_pkg::CTRL_ADDR, 32'h2);
        end
    endtask : scen_conds

    task automatic scen_ends();
        logic [2:0] seen;
        int         n;
        wr(step_seq_pkg::PROG_BASE, 32'h9522);
        for (int t = 0; t < 3; t++) begin
            wr(step_seq_pkg::PROG_BASE + 8'h14, {16'h0, 4'ha, 4'(8 + t), 4'h3, 4'hf});
            drv_u.set_lines(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            wr(step_seq_pkg::CTRL_ADDR, 32'h1);
            wait_step(3'h0);
            drv_u.set_lines(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
            wait_step(3'h5);
            chk(32'({ramp_set2, out_on, direction, preset_speed}), 32'h000d0555);
            drv_u.set_lines(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
            seen = 3'h0;
            n = 0;
            while (seen == 3'h0 && n < 100) begin
                @(posedge clk);
                seen = {abort_flt, s_coast, s_ramp};
                n++;
            end
            chk(32'(seen), 32'(1 << t));
            repeat (5) @(posedge clk);
            chk(32'(running), 32'h0);
        end
        // sticky fault must block a restart until cleared
        wr(step_seq_pkg::CTRL_ADDR, 32'h1);
        repeat (20) @(posedge clk);
        chk(32'({running, abort_flt}), 32'h1);
        wr(step_seq_pkg::CTRL_ADDR, 32'h4);
        repeat (5) @(posedge clk);
        chk(32'(abort_flt), 32'h0);
    endtask : scen_ends

    task automatic scen_wrap();
        wr(step_seq_pkg::PROG_BASE, 32'h372f);
        wr(step_seq_pkg::PROG_BASE + 8'h1c, 32'h00f0);
        drv_u.set_lines(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        drv_u.set_lines(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        wait_step(3'h0);
        drv_u.set_lines(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        wait_step(3'h7);
        wait_step(3'h0);
        drv_u.set_lines(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        repeat (10) @(posedge clk);
        chk(32'(running), 32'h0);
        drv_u.set_lines(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        wr(step_seq_pkg::CTRL_ADDR, 32'h1);
        repeat (10) @(posedge clk);
        chk(32'(running), 32'h1);
        drv_u.set_lines(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        repeat (10) @(posedge clk);
        chk(32'(running), 32'h0);
    endtask : scen_wrap

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        chk(32'(direction), 32'(step_seq_pkg::DIR_NONE));
        rdchk(step_seq_pkg::PROG_BASE + 8'h04, 32'(step_seq_pkg::PROG_RESET));
        rdchk(step_seq_pkg::DWELL_BASE, 32'(step_seq_pkg::DWELL_RESET));
        rdchk(8'hfc, 32'h0);
        // zero dwell keeps timed codes within the run length
        for (int i = 0; i < 8; i++) begin
            wr(step_seq_pkg::DWELL_BASE + 8'(4 * i), 32'h0);
        end
        wr(step_seq_pkg::SPEED_BASE, 32'h1234);
        wr(step_seq_pkg::SPEED_BASE + 8'h14, 32'h0555);
        wr(step_seq_pkg::PROG_BASE + 8'h04, 32'h00ff);
        scen_conds();
        scen_ends();
        scen_wrap();
        wrap_up();
    end
endmodule : step_sequencer_program_decoder_test
`default_nettype wire
